//--- adc_sequencer_control.sv
// successive-approximation converter sequencer with apb register access
// assumes the analog core accepts a sample strobe and returns a result on core_done
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - speed field picks longest conversion 530, 266, 134 or 68 states
// - two lowest control bits read zero and ignore writes
// - ten-bit results, single mode and scan mode only
// - one write may set go bit with new channel and interrupt enable
// - single mode: each go converts the selected channel once
// - single result lands in that channel's result register
// - single completion sets done flag, interrupt when enabled
// - single mode go reads one during conversion, clears at end
// - clearing go mid-conversion aborts to idle
// - sweep 10 sweep_span up to four channels, 11 from input 0 up to the selected channel
// - four-channel group starts at input 0, 4, 8 or 12; eight at 0
// - each scanned result stored in its slot on completion, groups at 0, 8 and 12 sharing slots 0 to 3
// - end of group sets done, interrupt, restarts at first channel
// - scan never clears go; restart begins at group's first channel
// - after go: start delay, then sampling, then conversion
// - sampling 127/63/31/15, delay 18/10/6/4 minimum states
// - later scan conversions take 512/256/128/64 states fixed
// - trigger source 11: falling edge on trigger pin sets go
// - done interrupt asserted while done flag and enable are one
// - done interrupt also usable as transfer controller request
// - result in bits 15..6, low six bits read zero
// - done clears on zero write after reading one, or on dma read
// - sweep 0x single, 10 four-channel scan, 11 eight-channel scan
module adc_sequencer_control
   import adc_seq_pkg::*;
#(
   parameter int NUM_RESULTS = 8
) (
   input  wire logic        pclk,            // system clock
   input  wire logic        presetn,         // async reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb enable
   input  wire logic        pwrite,          // apb direction
   input  wire logic [7:0]  paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic      [31:0] prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error on unmapped address
   input  wire logic        ext_trigger_pin, // external start, falling edge
   input  wire logic        xfer_ack,        // transfer controller serving the request
   input  wire logic        core_done,       // core result valid strobe
   input  wire logic [9:0]  core_result,     // core result
   output logic             sample_strobe,   // begin sample-and-hold window
   output logic             convert_strobe,  // begin approximation
   output logic      [3:0]  mux_channel,     // analog input select
   output logic             conversion_done_irq // done interrupt and transfer request
);

   logic                   go_q;
   logic                   done_q;
   logic                   ien_q;
   logic [3:0]             chan_q;
   ctrl_s                  ctrl_q;
   logic                   done_seen_q;
   logic                   trig_q;
   seq_state_e             state_q;
   logic [9:0]             cnt_q;
   logic [9:0]             cnt_lim;
   logic [3:0]             cur_q;
   logic                   first_q;
   logic [RESULT_BITS-1:0] res_q [NUM_RESULTS];
   logic                   wr_en;
   logic                   rd_en;
   logic                   is_res;
   logic                   mapped;
   logic                   trig_fall;
   logic                   conv_end;
   logic                   last_chan;
   logic [3:0]             first_chan;
   logic                   at_lim;
   logic [RESULT_BITS-1:0] hold_q;
   logic                   held_q;

   function automatic logic [9:0] cyc(input int v);
      return 10'(v);
   endfunction

   // register index of a converted input: groups at 0, 8 and 12 share slots 0 to 3
   function automatic logic [2:0] slot(input logic [3:0] ch);
      return ch[3] ? {1'b0, ch[1:0]} : ch[2:0];
   endfunction

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && penable && !pwrite;
   assign is_res  = (paddr < OFS_CSR) && (paddr[1:0] == 2'b00);
   assign mapped  = is_res || paddr == OFS_CSR || paddr == OFS_CTRL;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign trig_fall = trig_q && !ext_trigger_pin &&
                      ctrl_q.trig_src == TRG_EXT_PIN;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_q <= 1'b1;
      end else begin
         trig_q <= ext_trigger_pin;
      end
   end

   // four-channel scan keeps the group base, eight-channel starts at input 0
   always_comb begin
      if (ctrl_q.sweep == SWEEP_EIGHT) begin
         first_chan = 4'h0;
      end else if (ctrl_q.sweep == SWEEP_FOUR) begin
         first_chan = {chan_q[3:2], 2'b00};
      end else begin
         first_chan = chan_q;
      end
   end

   always_comb begin
      if (ctrl_q.sweep[1]) begin
         last_chan = cur_q == chan_q;
      end else begin
         last_chan = 1'b1;
      end
   end

   always_comb begin
      case (state_q)
         ST_DELAY:  cnt_lim = cyc(DELAY_MIN[ctrl_q.speed]);
         ST_SAMPLE: cnt_lim = cyc(SAMPLE_STATES[ctrl_q.speed]);
         ST_CONVERT: begin
            if (first_q) begin
               cnt_lim = cyc(CONV_MAX[ctrl_q.speed] - DELAY_MIN[ctrl_q.speed]
                             - SAMPLE_STATES[ctrl_q.speed]);
            end else begin
               cnt_lim = cyc(SCAN_NEXT[ctrl_q.speed]
                             - SAMPLE_STATES[ctrl_q.speed]);
            end
         end
         default:   cnt_lim = 10'h001;
      endcase
   end

   // first conversion ends on the core strobe or at its limit; later scan slots are fixed
   assign at_lim   = cnt_q >= cnt_lim - 10'h001;
   assign conv_end = state_q == ST_CONVERT && go_q &&
                     (first_q ? (core_done || at_lim) : at_lim);

   // an early core answer is held until its slot ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= '0;
         held_q <= 1'b0;
      end else if (conv_end || !go_q) begin
         held_q <= 1'b0;
      end else if (core_done) begin
         hold_q <= core_result;
         held_q <= 1'b1;
      end
   end

   // sequencing, every count in pclk cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cnt_q   <= 10'h000;
         cur_q   <= 4'h0;
         first_q <= 1'b1;
      end else if (!go_q) begin
         state_q <= ST_IDLE;
         cnt_q   <= 10'h000;
         first_q <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               state_q <= ST_DELAY;
               cur_q   <= first_chan;
               // the idle cycle after go counts as the first delay state
               cnt_q   <= 10'h001;
            end
            ST_DELAY, ST_SAMPLE: begin
               if (cnt_q >= cnt_lim - 10'h001) begin
                  cnt_q   <= 10'h000;
                  state_q <= state_q == ST_DELAY ? ST_SAMPLE : ST_CONVERT;
               end else begin
                  cnt_q <= cnt_q + 10'h001;
               end
            end
            ST_CONVERT: begin
               if (conv_end) begin
                  cnt_q   <= 10'h000;
                  first_q <= 1'b0;
                  state_q <= ST_SAMPLE;
                  cur_q   <= last_chan ? first_chan : cur_q + 4'h1;
               end else begin
                  cnt_q <= cnt_q + 10'h001;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign sample_strobe  = go_q && state_q == ST_DELAY && cnt_q >= cnt_lim - 10'h001;
   assign convert_strobe = go_q && state_q == ST_SAMPLE && cnt_q >= cnt_lim - 10'h001;
   assign mux_channel    = cur_q;

   // results; a latched value is kept until any channel sharing its slot is converted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_RESULTS; i++) begin
            res_q[i] <= '0;
         end
      end else if (conv_end) begin
         res_q[slot(cur_q)] <= core_done ? core_result :
                               (held_q ? hold_q : '0);
      end
   end

   // go bit: software, trigger pin, auto clear in single mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         go_q <= 1'b0;
      end else if (trig_fall) begin
         go_q <= 1'b1;
      end else if (wr_en && paddr == OFS_CSR) begin
         go_q <= pwdata[CSR_GO_POS];
      end else if (conv_end && !ctrl_q.sweep[1]) begin
         go_q <= 1'b0;
      end
   end

   // done flag: set wins over a clearing write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q      <= 1'b0;
         done_seen_q <= 1'b0;
      end else begin
         if (conv_end && last_chan) begin
            done_q <= 1'b1;
         end else if (wr_en && paddr == OFS_CSR && !pwdata[CSR_DONE_POS] && done_seen_q) begin
            done_q <= 1'b0;
         end else if (xfer_ack && rd_en && is_res) begin
            done_q <= 1'b0;
         end
         if (rd_en && paddr == OFS_CSR) begin
            done_seen_q <= done_q;
         end else if (!done_q) begin
            done_seen_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_q  <= CSR_RESET[CSR_IEN_POS];
         chan_q <= CSR_RESET[3:0];
      end else if (wr_en && paddr == OFS_CSR) begin
         ien_q  <= pwdata[CSR_IEN_POS];
         chan_q <= pwdata[3:0];
      end
   end

   // low two control bits are not stored at all
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= ctrl_s'(CTRL_RESET[7:2]);
      end else if (wr_en && paddr == OFS_CTRL) begin
         ctrl_q <= ctrl_s'(pwdata[7:2]);
      end
   end

   assign conversion_done_irq = done_q && ien_q;

   // read data is a flop so that it stays stable through the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (is_res) begin
            prdata <= {16'h0000, res_q[paddr[4:2]], 6'h00};
         end else if (paddr == OFS_CSR) begin
            prdata <= {24'h000000, done_q, ien_q, go_q, 1'b0, chan_q};
         end else if (paddr == OFS_CTRL) begin
            prdata <= {24'h000000, ctrl_q, 2'b00};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

endmodule

//--- adc_seq_pkg.sv
// package for the conversion sequencer: register map, field positions, timing counts
// assumes a 32-bit apb slave at pclk, one state equal to one pclk cycle
package adc_seq_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_RESULT_BASE = 8'h00;  // eight result words, 0x00..0x1c
   localparam logic [7:0] OFS_CSR         = 8'h20;  // control/status
   localparam logic [7:0] OFS_CTRL        = 8'h24;  // control

   // control/status field positions
   localparam int CSR_DONE_POS = 7;
   localparam int CSR_IEN_POS  = 6;
   localparam int CSR_GO_POS   = 5;

   // control field positions
   localparam int CTRL_TRG_POS   = 6;
   localparam int CTRL_SWEEP_POS = 4;
   localparam int CTRL_SPEED_POS = 2;

   // reset values
   localparam logic [7:0] CSR_RESET  = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   localparam logic [1:0] TRG_EXT_PIN = 2'b11;
   localparam logic [1:0] SWEEP_FOUR  = 2'b10;
   localparam logic [1:0] SWEEP_EIGHT = 2'b11;

   localparam int RESULT_BITS = 10;
   localparam int RESULT_POS  = 6;

   // timing counts in states, indexed by the speed select field
   localparam int SAMPLE_STATES [4] = '{127, 63, 31, 15};
   localparam int DELAY_MIN     [4] = '{18, 10, 6, 4};
   localparam int CONV_MAX      [4] = '{530, 266, 134, 68};
   localparam int SCAN_NEXT     [4] = '{512, 256, 128, 64};

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_SAMPLE,
      ST_CONVERT
   } seq_state_e;

   typedef struct packed {
      logic [1:0] trig_src;
      logic [1:0] sweep;
      logic [1:0] speed;
   } ctrl_s;

   typedef struct packed {
      logic [3:0]             chan;
      logic                   start;
      logic [RESULT_BITS-1:0] data;
      logic                   valid;
   } core_s;

endpackage

//--- adc_core_model.sv
// behavioural analog core: answers each convert strobe after a fixed latency
// assumes the sequencer holds mux_channel steady until the convert strobe
`timescale 1ns/1ps
module adc_core_model #(
   parameter int LAT = 10
) (
   input  wire logic       pclk,           // clock
   input  wire logic       presetn,        // reset, active low
   input  wire logic       convert_strobe, // approximation start
   input  wire logic [3:0] mux_channel,    // selected input
   input  wire logic [9:0] base,           // bench level
   output logic            core_done,      // result strobe
   output logic      [9:0] core_result     // result
);
   int         cnt_q;
   logic [3:0] ch_q;
   // between strobes the result toggles, so a stale value never passes for a fresh one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 0;
         ch_q <= 4'h0;
         core_done <= 1'b0;
         core_result <= 10'h000;
      end else begin
         core_done <= cnt_q == 1;
         core_result <= (cnt_q == 1) ? base ^ {6'h00, ch_q} : ~core_result;
         if (convert_strobe) begin
            cnt_q <= LAT;
            ch_q <= mux_channel;
         end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end
      end
   end
endmodule

//--- adc_sequencer_control_chk.sv
// assertion checker for the conversion sequencer, bound to its top module
// assumes software writes the go bit only while the sequencer is idle
`timescale 1ns/1ps
module adc_sequencer_control_chk
   import adc_seq_pkg::*;
(
   input wire logic        pclk,           // clock
   input wire logic        presetn,        // reset, active low
   input wire logic        psel,           // apb select
   input wire logic        penable,        // apb enable
   input wire logic        pwrite,         // apb direction
   input wire logic [7:0]  paddr,          // apb address
   input wire logic [31:0] pwdata,         // apb write data
   input wire logic [31:0] prdata,         // apb read data
   input wire logic        sample_strobe,  // sampling begins
   input wire logic        convert_strobe, // approximation begins
   input wire logic [3:0]  mux_channel     // selected input
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic       acc, go_wr, arm_q, arm2_q;
   logic [3:0] cfg_q, ch_q;
   int         dly_q, spl_q;
   assign acc = psel && penable;
   assign go_wr = acc && pwrite && paddr == OFS_CSR && pwdata[CSR_GO_POS];
   // only the first conversion after a go write has a known start, later ones are not timed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= 4'h0;
         ch_q <= 4'h0;
         arm_q <= 1'b0;
         arm2_q <= 1'b0;
         dly_q <= 0;
         spl_q <= 0;
      end else begin
         if (acc && pwrite && paddr == OFS_CTRL) cfg_q <= pwdata[5:2];
         if (go_wr) ch_q <= pwdata[3:0];
         arm_q <= go_wr || (arm_q && !sample_strobe);
         arm2_q <= (sample_strobe && arm_q) || (arm2_q && !convert_strobe);
         dly_q <= go_wr ? 1 : dly_q + 1;
         spl_q <= sample_strobe ? 1 : spl_q + 1;
      end
   end
   property p_ctrl_rsvd; acc && !pwrite && paddr == OFS_CTRL |-> prdata[1:0] == 2'b00; endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control low bits nonzero");
   property p_res_low; acc && !pwrite && paddr < OFS_CSR |-> prdata[5:0] == 6'h00; endproperty
   a_res_low: assert property (p_res_low) else $error("result low bits nonzero");
   property p_excl; convert_strobe |-> !sample_strobe && !$past(convert_strobe); endproperty
   a_excl: assert property (p_excl) else $error("strobes overlap");
   property p_delay; sample_strobe && arm_q |-> dly_q == DELAY_MIN[cfg_q[1:0]]; endproperty
   a_delay: assert property (p_delay) else $error("start delay length wrong");
   property p_sample; convert_strobe && arm2_q |-> spl_q == SAMPLE_STATES[cfg_q[1:0]]; endproperty
   a_sample: assert property (p_sample) else $error("sampling length wrong");
   property p_hold; sample_strobe |=> $stable(mux_channel) [*8]; endproperty
   a_hold: assert property (p_hold) else $error("channel moved while sampling");
   property p_abort; acc && pwrite && paddr == OFS_CSR && !pwdata[CSR_GO_POS]
      |=> (!sample_strobe && !convert_strobe) [*8]; endproperty
   a_abort: assert property (p_abort) else $error("activity after stop");
   property p_first_chan; sample_strobe && arm_q && cfg_q[3]
      |-> mux_channel == (cfg_q[2] ? 4'h0 : {ch_q[3:2], 2'b00}); endproperty
   a_first_chan: assert property (p_first_chan) else $error("scan first channel wrong");
   property p_single_chan; sample_strobe && arm_q && !cfg_q[3] |-> mux_channel == ch_q; endproperty
   a_single_chan: assert property (p_single_chan) else $error("single channel wrong");
endmodule

bind adc_sequencer_control adc_sequencer_control_chk adc_sequencer_control_chk_inst (.*);

//--- test_adc_sequencer_control.sv
// directed bench for the conversion sequencer over apb
// assumes the behavioural core model stands on the analog side
`timescale 1ns/1ps
module test_adc_sequencer_control
   import adc_seq_pkg::*;
();
   logic        pclk, presetn, psel, penable, pwrite, ext_trigger_pin, xfer_ack;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic        e;
   logic        pready, pslverr, core_done, sample_strobe, convert_strobe, conversion_done_irq;
   logic [9:0]  core_result, base;
   logic [3:0]  mux_channel;
   int          n_mismatch, cmp_count, n;

   adc_sequencer_control adc_sequencer_control_inst (.*);
   adc_core_model adc_core_model_inst (.*);

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 16) begin
         n_mismatch++;
         end_sim();
      end
      @(posedge pclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, r, e);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic wt(input bit on_irq);
      n = 0;
      while ((on_irq ? conversion_done_irq : convert_strobe) !== 1'b1 && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 5000) begin
         n_mismatch++;
         end_sim();
      end
   endtask

   function automatic logic [31:0] res(input logic [3:0] ch);
      return {16'h0, base ^ {6'h00, ch}, 6'h00};
   endfunction

   initial begin
      {presetn, psel, penable, pwrite, xfer_ack} = 5'b0;
      ext_trigger_pin = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      base = 10'h000;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFS_CSR, 32'h0, "csr reset");
      rd(OFS_CTRL, 32'h0, "ctrl reset");
      wr(OFS_CTRL, 32'hff);
      rd(OFS_CTRL, 32'hfc, "ctrl reserved");
      rd(8'h40, 32'h0, "unmapped");
      chk("unmapped err", {31'h0, e}, 32'h1);
      for (int s = 0; s < 4; s++) begin
         base <= 10'h2a5 + 10'(s);
         wr(OFS_CTRL, 32'(s) << CTRL_SPEED_POS);
         wr(OFS_CSR, 32'h64 + 32'(s));
         wt(1'b1);
         chk("conv time", {31'h0, n >= DELAY_MIN[s] + SAMPLE_STATES[s] && n <= CONV_MAX[s]}, 32'h1);
         rd(OFS_CSR, 32'hc4 + 32'(s), "single end");
         rd(8'(16 + 4 * s), res(4'(4 + s)), "single result");
         wr(OFS_CSR, 32'h44 + 32'(s));
         chk("irq clear", {31'h0, conversion_done_irq}, 32'h0);
      end
      // stop lands inside the sampling window, well before the core answers
      wr(OFS_CSR, 32'h61);
      repeat (10) @(posedge pclk);
      wr(OFS_CSR, 32'h41);
      repeat (300) @(posedge pclk);
      rd(OFS_CSR, 32'h41, "abort");
      base <= 10'h0f0;
      wr(OFS_CTRL, 32'h2c);
      wr(OFS_CSR, 32'h6f);
      wt(1'b1);
      wt(1'b0);
      chk("restart chan", {28'h0, mux_channel}, 32'hc);
      rd(OFS_CSR, 32'hef, "scan go held");
      wr(OFS_CSR, 32'hcf);
      xfer_ack <= 1'b1;
      rd(8'h00, res(4'hc), "scan first");
      xfer_ack <= 1'b0;
      rd(OFS_CSR, 32'h4f, "dma clear");
      for (int i = 1; i < 4; i++) rd(8'(4 * i), res(4'(12 + i)), "scan four");
      base <= 10'h30c;
      wr(OFS_CTRL, 32'h3c);
      wr(OFS_CSR, 32'h67);
      wt(1'b1);
      wr(OFS_CSR, 32'hc7);
      for (int i = 0; i < 8; i++) rd(8'(4 * i), res(4'(i)), "scan eight");
      base <= 10'h1c3;
      wr(OFS_CTRL, 32'hcc);
      rd(OFS_CSR, 32'hc7, "scan stop");
      wr(OFS_CSR, 32'h42);
      ext_trigger_pin <= 1'b0;
      repeat (3) @(posedge pclk);
      ext_trigger_pin <= 1'b1;
      wt(1'b1);
      rd(OFS_CSR, 32'hc2, "trigger start");
      rd(8'h08, res(4'h2), "trigger result");
      end_sim();
   end
endmodule
